/* File: inc/temp_alarm_pkg.sv */
// Constants, field layouts and carrier types for the temperature status and alarm logic.
// Assumes a 100 MHz core clock and a command-byte register port from the serial bus slave.
package temp_alarm_pkg;

   // Clock and power-up timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int POWERUP_MS = 30;
   localparam int POWERUP_CYCLES = (POWERUP_MS * 1000000) / CLK_PERIOD_NS;

   // Channel layout
   localparam int TEMP_W = 8;
   localparam int NUM_CH = 3;
   localparam int CH_LOCAL = 0;
   localparam int CH_REMOTE_A = 1;
   localparam int CH_REMOTE_B = 2;

   // Command bytes
   localparam logic [7:0] ADDR_COMMON_STATUS = 8'h02;
   localparam logic [7:0] ADDR_CONFIG = 8'h03;
   localparam logic [7:0] ADDR_CHAN_ENABLE = 8'h05;
   localparam logic [7:0] ADDR_DIODE_FAULT = 8'h07;
   localparam logic [7:0] ADDR_FIRST_ALARM = 8'h08;
   localparam logic [7:0] ADDR_SECOND_ALARM = 8'h09;
   localparam logic [7:0] ADDR_FIRST_MASK = 8'h0c;
   localparam logic [7:0] ADDR_SECOND_MASK = 8'h0d;
   localparam logic [7:0] ADDR_TRIGGER = 8'h0f;

   // Field positions
   localparam int CS_BUSY_BIT = 7;
   localparam int CS_NR_BIT = 6;
   localparam int CS_SUM4_BIT = 3;
   localparam int CS_SUM3_BIT = 2;
   localparam int CS_SUM2_BIT = 1;
   localparam int CS_SUM1_BIT = 0;
   localparam int CFG_STANDBY_BIT = 6;
   localparam int FLT_A_SHORT_BIT = 0;
   localparam int FLT_A_OPEN_BIT = 1;
   localparam int FLT_B_SHORT_BIT = 2;
   localparam int FLT_B_OPEN_BIT = 3;

   // Reset values
   localparam logic [7:0] COMMON_STATUS_RST = 8'h00;
   localparam logic [7:0] CONFIG_RST = 8'h00;
   localparam logic [7:0] CHAN_ENABLE_RST = 8'h1f;
   localparam logic [7:0] FIRST_MASK_RST = 8'h01;
   localparam logic [7:0] SECOND_MASK_RST = 8'h00;

   // Readout substituted while a diode fault is present
   localparam logic [7:0] FAULT_SIGNED_VAL = 8'h80;
   localparam logic [7:0] FAULT_UNSIGNED_VAL = 8'h00;

   typedef logic signed [TEMP_W-1:0] temp_t;

   // Limits and shared hysteresis from the limit registers
   typedef struct packed {
      temp_t local_crit;
      temp_t ra_first;
      temp_t rb_first;
      temp_t ra_second;
      temp_t rb_second;
      logic [TEMP_W-1:0] hyst;
   } limit_cfg_t;

   // Diode input comparator levels of one remote channel
   typedef struct packed {
      logic to_gnd;
      logic to_neg;
      logic to_vdd;
      logic floating;
   } diode_sense_t;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_PICK, SEQ_REQ, SEQ_WAIT} seq_state_t;

endpackage

/* File: hdl/alarm_hyst_cell.sv */
// One alarm status flag with shared hysteresis.
// Assumes upd_i is a one-cycle pulse at the end of the channel's conversion.
`timescale 1ns/1ps
module alarm_hyst_cell
   import temp_alarm_pkg::*;
#(
   parameter int W = TEMP_W
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Comparison inputs
   input wire logic upd_i,
   input wire logic signed [W-1:0] reading_i,
   input wire logic signed [W-1:0] limit_i,
   input wire logic [W-1:0] hyst_i,
   // Flag
   output logic flag_o
);

   // Two guard bits so limit minus hysteresis cannot wrap
   wire logic signed [W+1:0] rd_x = {{2{reading_i[W-1]}}, reading_i};
   wire logic signed [W+1:0] lim_x = {{2{limit_i[W-1]}}, limit_i};
   wire logic signed [W+1:0] hy_x = {2'b00, hyst_i};
   wire logic signed [W+1:0] clr_thr = lim_x - hy_x;
   wire logic set_c = (rd_x >= lim_x);
   wire logic clr_c = (rd_x < clr_thr);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flag_o <= 1'b0;
      end else if (upd_i) begin
         if (set_c) begin
            flag_o <= 1'b1;
         end else if (clr_c) begin
            flag_o <= 1'b0;
         end
      end
   end

   property p_flag_set;
      @(posedge clk_i) disable iff (!rstn_i) (upd_i && set_c) |=> flag_o;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set at limit");

   property p_flag_band;
      @(posedge clk_i) disable iff (!rstn_i)
         (upd_i && !set_c && !clr_c) |=> (flag_o == $past(flag_o));
   endproperty
   a_flag_band: assert property (p_flag_band) else $error("flag moved in band");

   property p_flag_clear;
      @(posedge clk_i) disable iff (!rstn_i) (upd_i && clr_c) |=> !flag_o;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

endmodule

/* File: hdl/temp_status_alarm_logic.sv */
// Status, trigger and alarm logic of a three channel temperature monitor.
// Assumes a command-byte register port from the serial slave on the same clock,
// a converter that answers each request with one conv_done_i pulse, and
// asynchronous diode comparator levels from the analog front end.
`timescale 1ns/1ps
module temp_status_alarm_logic
   import temp_alarm_pkg::*;
#(
   parameter int POWERUP_LEN = POWERUP_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Register port from the serial slave
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Converter handshake
   output logic conv_req_o,
   output logic [1:0] conv_chan_o,
   input wire logic conv_done_i,
   input wire temp_t conv_temp_i,
   // Limits and analog diode levels
   input wire limit_cfg_t limits_i,
   input wire diode_sense_t [1:0] diode_sense_i,
   // Readouts and alarm pins
   output logic [NUM_CH-1:0][TEMP_W-1:0] temp_signed_o,
   output logic [NUM_CH-1:0][TEMP_W-1:0] temp_unsigned_o,
   output logic first_alarm_output_n_o,
   output logic second_alarm_output_n_o
);

   localparam int PU_W = $clog2(POWERUP_LEN + 1);
   localparam logic [PU_W-1:0] PU_LAST = PU_W'(POWERUP_LEN - 1);

   // Lowest enabled channel at or above a start index; MSB flags a hit
   function automatic logic [2:0] next_chan(input logic [2:0] en, input logic [1:0] from);
      logic [2:0] res;
      res = 3'b000;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (en[i] && (i >= int'(from))) begin
            res = {1'b1, 2'(i)};
         end
      end
      return res;
   endfunction

   // Limit of one alarm flag; local shares one critical limit
   function automatic temp_t lim_of(input limit_cfg_t c, input int a, input int ch);
      temp_t l;
      l = c.local_crit;
      if (ch == CH_REMOTE_A) begin
         l = (a == 0) ? c.ra_first : c.ra_second;
      end else if (ch == CH_REMOTE_B) begin
         l = (a == 0) ? c.rb_first : c.rb_second;
      end
      return l;
   endfunction

   // Reset release through two flops
   logic rst_m_r;
   logic rstn_s;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_m_r <= 1'b0;
         rstn_s <= 1'b0;
      end else begin
         rst_m_r <= 1'b1;
         rstn_s <= rst_m_r;
      end
   end

   // Diode levels are analog comparator outputs, so synchronise them
   diode_sense_t [1:0] sense_m_r;
   diode_sense_t [1:0] sense_s_r;
   always_ff @(posedge clk_i or negedge rstn_s) begin
      if (!rstn_s) begin
         sense_m_r <= '0;
         sense_s_r <= '0;
      end else begin
         sense_m_r <= diode_sense_i;
         sense_s_r <= sense_m_r;
      end
   end

   // Control registers
   logic standby_r;
   logic [2:0] chan_en_r;
   logic [2:0] mask1_r;
   logic [2:0] mask2_r;
   wire logic wr_cfg = reg_wr_i && (reg_addr_i == ADDR_CONFIG);
   wire logic wr_en = reg_wr_i && (reg_addr_i == ADDR_CHAN_ENABLE);
   wire logic wr_m1 = reg_wr_i && (reg_addr_i == ADDR_FIRST_MASK);
   wire logic wr_m2 = reg_wr_i && (reg_addr_i == ADDR_SECOND_MASK);
   // data of a trigger write is never stored
   wire logic wr_trig = reg_wr_i && (reg_addr_i == ADDR_TRIGGER);

   // standby bit and other writable controls
   always_ff @(posedge clk_i or negedge rstn_s) begin
      if (!rstn_s) begin
         standby_r <= CONFIG_RST[CFG_STANDBY_BIT];
         chan_en_r <= CHAN_ENABLE_RST[2:0];
         mask1_r <= FIRST_MASK_RST[2:0];
         mask2_r <= SECOND_MASK_RST[2:0];
      end else begin
         if (wr_cfg) standby_r <= reg_wdata_i[CFG_STANDBY_BIT];
         if (wr_en) chan_en_r <= reg_wdata_i[2:0];
         if (wr_m1) mask1_r <= reg_wdata_i[2:0];
         if (wr_m2) mask2_r <= reg_wdata_i[2:0];
      end
   end

   // power-up not-ready window; the flag rises on the first edge after release
   logic nr_r;
   logic pu_done_r;
   logic [PU_W-1:0] pu_cnt_r;
   always_ff @(posedge clk_i or negedge rstn_s) begin
      if (!rstn_s) begin
         nr_r <= 1'b0;
         pu_done_r <= 1'b0;
         pu_cnt_r <= '0;
      end else if (!pu_done_r) begin
         nr_r <= (pu_cnt_r != PU_LAST);
         pu_done_r <= (pu_cnt_r == PU_LAST);
         pu_cnt_r <= pu_cnt_r + 1'b1;
      end
   end

   // Conversion sequencer
   seq_state_t state_r;
   logic [1:0] chan_r;
   logic shot_pend_r;
   logic conv_req_r;
   wire logic [2:0] pick = next_chan(chan_en_r, chan_r);
   wire logic busy = (state_r != SEQ_IDLE);
   wire logic start_pass = (state_r == SEQ_IDLE) && pu_done_r && (!standby_r || shot_pend_r);
   wire logic conv_end = (state_r == SEQ_WAIT) && conv_done_i;

   // a trigger only counts in standby; the set wins over the pass start
   always_ff @(posedge clk_i or negedge rstn_s) begin
      if (!rstn_s) begin
         shot_pend_r <= 1'b0;
      end else if (wr_trig && standby_r) begin
         shot_pend_r <= 1'b1;
      end else if (start_pass || !standby_r) begin
         shot_pend_r <= 1'b0;
      end
   end

   // one pass visits each enabled channel once, lowest index first
   always_ff @(posedge clk_i or negedge rstn_s) begin
      if (!rstn_s) begin
         state_r <= SEQ_IDLE;
         chan_r <= 2'h0;
         conv_req_r <= 1'b0;
      end else begin
         conv_req_r <= 1'b0;
         case (state_r)
            SEQ_IDLE: begin
               if (start_pass) begin
                  chan_r <= 2'h0;
                  state_r <= SEQ_PICK;
               end
            end
            SEQ_PICK: begin
               if (pick[2]) begin
                  chan_r <= pick[1:0];
                  conv_req_r <= 1'b1;
                  state_r <= SEQ_REQ;
               end else begin
                  state_r <= SEQ_IDLE;
               end
            end
            SEQ_REQ: begin
               state_r <= SEQ_WAIT;
            end
            SEQ_WAIT: begin
               if (conv_done_i) begin
                  chan_r <= chan_r + 2'h1;
                  state_r <= SEQ_PICK;
               end
            end
            default: begin
               state_r <= SEQ_IDLE;
            end
         endcase
      end
   end

   // fault classes from the synchronised diode levels
   wire logic [1:0] short_now = {sense_s_r[1].to_gnd | sense_s_r[1].to_neg,
                                 sense_s_r[0].to_gnd | sense_s_r[0].to_neg};
   wire logic [1:0] open_now = {sense_s_r[1].to_vdd | sense_s_r[1].floating,
                                sense_s_r[0].to_vdd | sense_s_r[0].floating};
   wire logic [1:0] rem_idx = chan_r - 2'h1;
   wire logic cur_fault = (chan_r != 2'h0) && (short_now[rem_idx[0]] | open_now[rem_idx[0]]);
   // faulted remote reports the floor of each format
   wire temp_t rep_signed = cur_fault ? temp_t'(FAULT_SIGNED_VAL) : conv_temp_i;
   wire logic [7:0] rep_unsigned = (cur_fault || conv_temp_i[TEMP_W-1]) ?
                                   FAULT_UNSIGNED_VAL : conv_temp_i;
   wire logic [NUM_CH-1:0] upd = {NUM_CH{conv_end}} & (3'b001 << chan_r);

   // fault bits and readouts refresh at each channel's conversion end
   logic [3:0] fault_r;
   logic [NUM_CH-1:0][TEMP_W-1:0] tsig_r;
   logic [NUM_CH-1:0][TEMP_W-1:0] tuns_r;
   always_ff @(posedge clk_i or negedge rstn_s) begin
      if (!rstn_s) begin
         fault_r <= 4'h0;
         tsig_r <= '0;
         tuns_r <= '0;
      end else if (conv_end) begin
         tsig_r[chan_r] <= rep_signed;
         tuns_r[chan_r] <= rep_unsigned;
         if (upd[CH_REMOTE_A]) begin
            fault_r[FLT_A_SHORT_BIT] <= short_now[0];
            fault_r[FLT_A_OPEN_BIT] <= open_now[0];
         end
         if (upd[CH_REMOTE_B]) begin
            fault_r[FLT_B_SHORT_BIT] <= short_now[1];
            fault_r[FLT_B_OPEN_BIT] <= open_now[1];
         end
      end
   end

   // alarm flags, one cell per alarm and channel
   logic [1:0][NUM_CH-1:0] alarm_flag;
   for (genvar a = 0; a < 2; a++) begin : g_alarm
      for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
         alarm_hyst_cell #(.W(TEMP_W)) u_cell (
            .clk_i(clk_i),
            .rstn_i(rstn_s),
            .upd_i(upd[c]),
            .reading_i(rep_signed),
            .limit_i(lim_of(limits_i, a, c)),
            .hyst_i(limits_i.hyst),
            .flag_o(alarm_flag[a][c])
         );
      end
   end

   wire logic first_act = |(alarm_flag[0] & ~mask1_r);
   wire logic second_act = |(alarm_flag[1] & ~mask2_r);

   // read selection; unmapped and write-only commands read zero
   wire logic [7:0] common_status = {busy, nr_r, 2'b00, 1'b0, |alarm_flag[1],
                                     |alarm_flag[0], |fault_r};
   wire logic [7:0] rd_value =
      (reg_addr_i == ADDR_COMMON_STATUS) ? common_status :
      (reg_addr_i == ADDR_CONFIG) ? {1'b0, standby_r, 6'h00} :
      (reg_addr_i == ADDR_CHAN_ENABLE) ? {5'h00, chan_en_r} :
      (reg_addr_i == ADDR_DIODE_FAULT) ? {4'h0, fault_r} :
      (reg_addr_i == ADDR_FIRST_ALARM) ? {5'h00, alarm_flag[0]} :
      (reg_addr_i == ADDR_SECOND_ALARM) ? {5'h00, alarm_flag[1]} :
      (reg_addr_i == ADDR_FIRST_MASK) ? {5'h00, mask1_r} :
      (reg_addr_i == ADDR_SECOND_MASK) ? {5'h00, mask2_r} : 8'h00;

   // Registered outputs; the pins lag the flags by one cycle
   logic [7:0] rdata_r;
   logic rvalid_r;
   logic alarm1_n_r;
   logic alarm2_n_r;
   always_ff @(posedge clk_i or negedge rstn_s) begin
      if (!rstn_s) begin
         rdata_r <= COMMON_STATUS_RST;
         rvalid_r <= 1'b0;
         alarm1_n_r <= 1'b1;
         alarm2_n_r <= 1'b1;
      end else begin
         rvalid_r <= reg_rd_i;
         if (reg_rd_i) rdata_r <= rd_value;
         alarm1_n_r <= ~first_act;
         alarm2_n_r <= ~second_act;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign reg_rvalid_o = rvalid_r;
   assign conv_req_o = conv_req_r;
   assign conv_chan_o = chan_r;
   assign temp_signed_o = tsig_r;
   assign temp_unsigned_o = tuns_r;
   assign first_alarm_output_n_o = alarm1_n_r;
   assign second_alarm_output_n_o = alarm2_n_r;

   property p_pend_cause;
      @(posedge clk_i) disable iff (!rstn_s) $rose(shot_pend_r) |-> $past(wr_trig && standby_r);
   endproperty
   a_pend_cause: assert property (p_pend_cause) else $error("trigger pending without cause");

   property p_trig_reads_zero;
      @(posedge clk_i) disable iff (!rstn_s)
         (reg_rd_i && reg_addr_i == ADDR_TRIGGER) |=> (reg_rvalid_o && reg_rdata_o == 8'h00);
   endproperty
   a_trig_reads_zero: assert property (p_trig_reads_zero) else $error("trigger read nonzero");

   property p_busy_bit;
      @(posedge clk_i) disable iff (!rstn_s)
         (reg_rd_i && reg_addr_i == ADDR_COMMON_STATUS && state_r != SEQ_IDLE)
         |=> reg_rdata_o[CS_BUSY_BIT];
   endproperty
   a_busy_bit: assert property (p_busy_bit) else $error("busy bit low while converting");

   property p_nr_len;
      @(posedge clk_i) disable iff (!rstn_s) $fell(nr_r) |-> ($past(pu_cnt_r) == PU_LAST);
   endproperty
   a_nr_len: assert property (p_nr_len) else $error("not-ready ended early");

   property p_summary;
      @(posedge clk_i) disable iff (!rstn_s)
         (reg_rd_i && reg_addr_i == ADDR_COMMON_STATUS) |=>
         (reg_rdata_o[5:0] == {3'b000, |$past(alarm_flag[1]), |$past(alarm_flag[0]),
                               |$past(fault_r)});
   endproperty
   a_summary: assert property (p_summary) else $error("summary bits wrong");

   property p_short_a;
      @(posedge clk_i) disable iff (!rstn_s)
         upd[CH_REMOTE_A] |=> (fault_r[FLT_A_SHORT_BIT] == $past(short_now[0]));
   endproperty
   a_short_a: assert property (p_short_a) else $error("remote A short not captured");

   property p_fault_readout;
      @(posedge clk_i) disable iff (!rstn_s)
         (fault_r[FLT_B_SHORT_BIT] || fault_r[FLT_B_OPEN_BIT]) |->
         (temp_signed_o[CH_REMOTE_B] == FAULT_SIGNED_VAL &&
          temp_unsigned_o[CH_REMOTE_B] == FAULT_UNSIGNED_VAL);
   endproperty
   a_fault_readout: assert property (p_fault_readout) else $error("faulted readout wrong");

   property p_first_pin;
      @(posedge clk_i) disable iff (!rstn_s)
         (|(alarm_flag[0] & ~mask1_r)) [*2] |-> !first_alarm_output_n_o;
   endproperty
   a_first_pin: assert property (p_first_pin) else $error("first alarm pin inactive");

   property p_second_pin;
      @(posedge clk_i) disable iff (!rstn_s)
         (!second_act) [*2] |-> second_alarm_output_n_o;
   endproperty
   a_second_pin: assert property (p_second_pin) else $error("second alarm pin stuck");

   property p_req_enabled;
      @(posedge clk_i) disable iff (!rstn_s) conv_req_o |-> chan_en_r[conv_chan_o];
   endproperty
   a_req_enabled: assert property (p_req_enabled) else $error("disabled channel converted");

   c_shot_pass: cover property (@(posedge clk_i) disable iff (!rstn_s)
      (wr_trig && standby_r && !busy) ##[1:4] conv_req_o);
   c_first_alarm: cover property (@(posedge clk_i) disable iff (!rstn_s)
      $fell(first_alarm_output_n_o));
   c_fault: cover property (@(posedge clk_i) disable iff (!rstn_s) $rose(|fault_r));
   c_nr_done: cover property (@(posedge clk_i) disable iff (!rstn_s) $fell(nr_r));

endmodule

/* File: dv/conv_model.sv */
// Behavioural converter that answers each conversion request with one done pulse.
// Assumes requests come one at a time; slow_i stretches the answer for the next request.
`timescale 1ns/1ps
module conv_model
   import temp_alarm_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Request side
   input wire logic conv_req_i,
   input wire logic [1:0] conv_chan_i,
   input wire logic slow_i,
   input wire logic [2:0][7:0] temps_i,
   // Answer side
   output logic conv_done_o,
   output temp_t conv_temp_o
);
   int wait_r;
   logic busy_r;
   logic [1:0] chan_r;

   // Result only valid with done; otherwise the bus toggles so nothing stale looks usable
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         conv_done_o <= 1'b0;
         conv_temp_o <= 8'h00;
         busy_r <= 1'b0;
         chan_r <= 2'h0;
         wait_r <= 0;
      end else begin
         conv_done_o <= 1'b0;
         conv_temp_o <= ~conv_temp_o;
         if (conv_req_i) begin
            busy_r <= 1'b1;
            chan_r <= conv_chan_i;
            wait_r <= slow_i ? 7 : 2;
         end else if (busy_r && wait_r == 0) begin
            conv_done_o <= 1'b1;
            conv_temp_o <= temps_i[chan_r];
            busy_r <= 1'b0;
         end else if (busy_r) begin
            wait_r <= wait_r - 1;
         end
      end
   end
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the temperature status and alarm logic.
// Assumes the converter model beside it; register reads are checked from a queue.
`timescale 1ns/1ps
module testbench;
   import temp_alarm_pkg::*;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic [7:0] reg_rdata_o;
   logic reg_rvalid_o;
   logic conv_req_o;
   logic [1:0] conv_chan_o;
   logic conv_done_i;
   temp_t conv_temp_i;
   logic slow = 1'b0;
   logic [2:0][7:0] temps = '0;
   // Limits: local 50, A 40/70, B 60/80, hysteresis 5
   limit_cfg_t limits = {8'h32, 8'h28, 8'h3c, 8'h46, 8'h50, 8'h05};
   diode_sense_t [1:0] sense = '0;
   logic [NUM_CH-1:0][TEMP_W-1:0] tsig;
   logic [NUM_CH-1:0][TEMP_W-1:0] tuns;
   logic first_n;
   logic second_n;
   logic [15:0] exp_q[$];
   logic [15:0] ent;
   int miscompares = 0;
   int check_count = 0;
   int req_cnt = 0;
   // Channels the bench has enabled; every request must name one of them
   logic [2:0] en_exp = 3'h7;

   initial forever #5 clk_i = ~clk_i;

   temp_status_alarm_logic #(.POWERUP_LEN(20)) temp_status_alarm_logic_i (
      .clk_i(clk_i), .rstn_i(rstn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o), .conv_req_o(conv_req_o), .conv_chan_o(conv_chan_o),
      .conv_done_i(conv_done_i), .conv_temp_i(conv_temp_i), .limits_i(limits),
      .diode_sense_i(sense), .temp_signed_o(tsig), .temp_unsigned_o(tuns),
      .first_alarm_output_n_o(first_n), .second_alarm_output_n_o(second_n));

   conv_model conv_model_i (
      .clk_i(clk_i), .rstn_i(rstn_i), .conv_req_i(conv_req_o), .conv_chan_i(conv_chan_o),
      .slow_i(slow), .temps_i(temps), .conv_done_o(conv_done_i), .conv_temp_o(conv_temp_i));

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      check_count++;
      if (s !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, s);
         miscompares++;
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // One-cycle strobes; the idle edge between calls keeps drives apart
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      exp_q.push_back({a, e});
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
   endtask

   // Trigger one pass, check busy mid-pass and that exactly n requests follow
   task automatic run_pass(input logic [7:0] st, input int n);
      int base;
      base = req_cnt;
      wr(ADDR_TRIGGER, 8'($urandom));
      rd(ADDR_COMMON_STATUS, st);
      for (int i = 0; i < 300 && req_cnt < base + n; i++) @(posedge clk_i);
      if (req_cnt < base + n) begin
         miscompares++;
         report_and_stop();
      end
      repeat (30) @(posedge clk_i);
      chk("conv_requests", 8'(base + n), 8'(req_cnt));
   endtask

   // Non-blocking count, so readers at the same edge see a settled value
   always @(posedge clk_i) begin
      if (conv_req_o === 1'b1) begin
         req_cnt <= req_cnt + 1;
         chk("conv_chan", 8'h01, 8'(en_exp[conv_chan_o]));
      end
   end

   // Read answers are matched against the oldest note
   always @(posedge clk_i) begin
      if (reg_rvalid_o === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("unexpected_read", 8'h00, 8'hff);
         end else begin
            ent = exp_q.pop_front();
            chk($sformatf("reg_%h", ent[15:8]), ent[7:0], reg_rdata_o);
         end
      end
   end

   initial begin
      int r;
      r = $urandom(55);
      repeat (8) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("first_pin", 8'h01, 8'(first_n));
      wr(ADDR_CONFIG, 8'h40);
      rd(ADDR_COMMON_STATUS, 8'h40);
      repeat (40) @(posedge clk_i);
      rd(ADDR_COMMON_STATUS, 8'h00);
      chk("idle_requests", 8'h00, 8'(req_cnt));
      // Pass with remote A exactly at its first limit
      temps <= {8'h1e, 8'h28, 8'h37};
      run_pass(8'h80, 3);
      rd(ADDR_FIRST_ALARM, 8'h03);
      rd(ADDR_SECOND_ALARM, 8'h01);
      rd(ADDR_COMMON_STATUS, 8'h06);
      rd(ADDR_TRIGGER, 8'h00);
      rd(ADDR_DIODE_FAULT, 8'h00);
      chk("first_pin", 8'h00, 8'(first_n));
      chk("second_pin", 8'h00, 8'(second_n));
      // Local in the hysteresis band, A below it, B over its limit
      temps <= {8'h3d, 8'h22, 8'h2f};
      slow <= 1'b1;
      run_pass(8'h86, 3);
      rd(ADDR_FIRST_ALARM, 8'h05);
      rd(ADDR_SECOND_ALARM, 8'h01);
      chk("first_pin", 8'h00, 8'(first_n));
      chk("second_pin", 8'h00, 8'(second_n));
      wr(ADDR_FIRST_MASK, 8'h05);
      wr(ADDR_SECOND_MASK, 8'h01);
      repeat (3) @(posedge clk_i);
      chk("first_pin", 8'h01, 8'(first_n));
      chk("second_pin_masked", 8'h01, 8'(second_n));
      wr(ADDR_SECOND_MASK, 8'h00);
      // Faults on both remotes while their readings would trip every limit
      sense[1].floating <= 1'b1;
      sense[0].to_neg <= 1'b1;
      temps <= {8'h5a, 8'h5a, 8'h2c};
      slow <= 1'b0;
      run_pass(8'h86, 3);
      rd(ADDR_DIODE_FAULT, 8'h09);
      rd(ADDR_FIRST_ALARM, 8'h00);
      rd(ADDR_SECOND_ALARM, 8'h00);
      rd(ADDR_COMMON_STATUS, 8'h01);
      chk("signed_a", 8'h80, tsig[1]);
      chk("unsigned_b", 8'h00, tuns[2]);
      chk("signed_local", 8'h2c, tsig[0]);
      chk("second_pin", 8'h01, 8'(second_n));
      // Remote A disabled: the pass skips it and its fault bits stay as they were
      wr(ADDR_CHAN_ENABLE, 8'h05);
      en_exp <= 3'h5;
      rd(ADDR_CHAN_ENABLE, 8'h05);
      run_pass(8'h81, 2);
      rd(ADDR_DIODE_FAULT, 8'h09);
      // Active mode converts without a trigger
      wr(ADDR_CONFIG, 8'h00);
      r = req_cnt;
      repeat (80) @(posedge clk_i);
      chk("continuous", 8'h01, 8'(req_cnt >= r + 3));
      // A trigger in active mode must leave nothing queued for standby
      wr(ADDR_TRIGGER, 8'($urandom));
      wr(ADDR_CONFIG, 8'h40);
      repeat (40) @(posedge clk_i);
      r = req_cnt;
      repeat (60) @(posedge clk_i);
      chk("standby_quiet", 8'(r), 8'(req_cnt));
      rd(8'h55, 8'h00);
      repeat (5) @(posedge clk_i);
      chk("pending_reads", 8'h00, 8'(exp_q.size()));
      report_and_stop();
   end
endmodule
